//--- psg_top.sv
// two stepper pulse train generators behind an axi4-lite register slave
// Overview of operation
// - two generators, fixed to pin one and two
// - active generator overrides program level on pin
// - each unaborted job except a long jog emits exactly step_count pulses
// - train runs accelerate, run, then decelerate
// - step and direction driven to motor driver
// - start or jog accepted only when enabled
// - enable ignored unless enable-release set
// - start rising edge begins normal job
// - jog rising edge begins jog mode
// - jog variant chosen by jog hold time
// - short jog: start frequency until release, then ramp to jog, step_count pulses, stop
// - long jog: half second at start, then jog
// - long jog release ramps down to start, stops
// - ramp rates are millihertz per step
// - job_running high while job in progress
// - abort edge brakes; running clears after braking
`include "psg_map.svh"

module psg_gen #(
  parameter int CLK_HZ = 50_000_000,
  parameter int JOG_HOLD_CYCLES = 25_000_000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire psg_pkg::psg_cfg_s cfg,
  output psg_pkg::psg_stat_s stat,
  output logic step_pin,
  output logic dir_pin,
  output logic active
);
  localparam logic [36:0] MOD = 37'(64'(CLK_HZ) * `PSG_MHZ_PER_HZ);
  localparam logic [36:0] HALF = MOD >> 1;
  localparam int TW = $clog2(JOG_HOLD_CYCLES + 1);
  localparam logic [TW-1:0] TLAST = TW'(JOG_HOLD_CYCLES - 1);

  psg_pkg::psg_state_e state;
  logic [31:0] cur, tgt, remaining, done;
  logic [36:0] acc;
  logic [TW-1:0] jog_tmr;
  logic free_run, freq_jog, dir_q, en_q, start_q, jog_q, abort_q, pin_q;

  // -----------------------------------------------------------------
  // request edges and enable
  // -----------------------------------------------------------------
  wire logic en_eff = cfg.ctrl[`PSG_C_ENREL] ? cfg.ctrl[`PSG_C_EN] : 1'b1;
  wire logic en_fall = en_q & ~en_eff;
  wire logic start_rise = cfg.ctrl[`PSG_C_START] & ~start_q;
  wire logic jog_rise = cfg.ctrl[`PSG_C_JOG] & ~jog_q;
  wire logic abort_rise = cfg.ctrl[`PSG_C_ABORT] & ~abort_q;
  wire logic busy = state != psg_pkg::ST_IDLE;
  wire logic [31:0] fs = 32'(cfg.start_hz * `PSG_MHZ_PER_HZ);
  wire logic [31:0] f_run = 32'(cfg.run_hz * `PSG_MHZ_PER_HZ);
  wire logic [31:0] f_jog = 32'(cfg.jog_hz * `PSG_MHZ_PER_HZ);
  wire logic ok_job = en_eff && fs != '0 && cfg.steps != '0;

  // -----------------------------------------------------------------
  // step rate accumulator and ramps
  // -----------------------------------------------------------------
  wire logic [36:0] acc_sum = acc + 37'(cur);
  wire logic step = busy && acc_sum >= MOD;
  wire logic [36:0] next_acc = step ? acc_sum - MOD : acc_sum;
  wire logic [32:0] up_sum = 33'(cur) + 33'(cfg.ramp_up);
  wire logic [31:0] cur_up = up_sum >= 33'(tgt) ? tgt : up_sum[31:0];
  wire logic dn_room = 33'(cur) > 33'(fs) + 33'(cfg.ramp_down);
  wire logic [31:0] cur_dn = dn_room ? cur - cfg.ramp_down : fs;
  wire logic [31:0] over = cur > fs ? cur - fs : '0;
  wire logic [63:0] rem_rd = 64'(remaining - 32'h0000_0001) * 64'(cfg.ramp_down);
  wire logic need_brake = !free_run && rem_rd <= 64'(over);
  wire logic last_step = step && !free_run && remaining == 32'h0000_0001;
  wire logic at_top = cur_up == tgt;
  wire logic jog_let_go = freq_jog && !cfg.ctrl[`PSG_C_JOG];

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    en_q <= aresetn & en_eff;
    start_q <= aresetn & cfg.ctrl[`PSG_C_START];
    jog_q <= aresetn & cfg.ctrl[`PSG_C_JOG];
    abort_q <= aresetn & cfg.ctrl[`PSG_C_ABORT];
    pin_q <= aresetn && busy && acc < HALF;
    if (!aresetn || en_fall) begin
      state <= psg_pkg::ST_IDLE;
      cur <= '0;
      tgt <= '0;
      remaining <= '0;
      done <= '0;
      acc <= '0;
      jog_tmr <= '0;
      free_run <= 1'b0;
      freq_jog <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      if (busy) begin
        acc <= next_acc;
      end
      if (step) begin
        done <= done + 32'h0000_0001;
        if (!free_run) begin
          remaining <= remaining - 32'h0000_0001;
        end
      end
      if (busy && abort_rise && state != psg_pkg::ST_DECEL && !last_step) begin
        state <= psg_pkg::ST_DECEL;
        free_run <= 1'b1;
      end else begin
        case (state)
          psg_pkg::ST_IDLE: begin
            if (ok_job && (start_rise || jog_rise)) begin
              state <= start_rise ? psg_pkg::ST_ACCEL : psg_pkg::ST_HOLD;
              tgt <= start_rise ? f_run : f_jog;
              cur <= fs;
              acc <= '0;
              remaining <= cfg.steps;
              done <= '0;
              dir_q <= cfg.ctrl[`PSG_C_DIR];
              jog_tmr <= '0;
              free_run <= 1'b0;
              freq_jog <= 1'b0;
            end
          end
          psg_pkg::ST_HOLD: begin
            jog_tmr <= jog_tmr + 1'b1;
            if (last_step) begin
              state <= psg_pkg::ST_IDLE;
            end else if (!cfg.ctrl[`PSG_C_JOG]) begin
              state <= psg_pkg::ST_ACCEL;
            end else if (jog_tmr == TLAST) begin
              state <= psg_pkg::ST_ACCEL;
              free_run <= 1'b1;
              freq_jog <= 1'b1;
            end
          end
          psg_pkg::ST_ACCEL: begin
            if (last_step) begin
              state <= psg_pkg::ST_IDLE;
            end else if (jog_let_go || (step && need_brake)) begin
              state <= psg_pkg::ST_DECEL;
            end else if (step) begin
              cur <= cur_up;
              if (at_top) begin
                state <= psg_pkg::ST_RUN;
              end
            end
          end
          psg_pkg::ST_RUN: begin
            if (last_step) begin
              state <= psg_pkg::ST_IDLE;
            end else if (jog_let_go || (step && need_brake)) begin
              state <= psg_pkg::ST_DECEL;
            end
          end
          psg_pkg::ST_DECEL: begin
            if (last_step || (step && free_run && cur <= fs)) begin
              state <= psg_pkg::ST_IDLE;
            end else if (step) begin
              cur <= cur_dn;
            end
          end
          default: state <= psg_pkg::ST_IDLE;
        endcase
      end
    end
  end

  assign stat = '{job_running: busy, freq_jog: freq_jog, state: state,
                  steps_done: done, cur_mhz: cur};
  assign step_pin = pin_q;
  assign dir_pin = dir_q;
  assign active = busy;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_exact_count: assert property (
    busy && last_step && !en_fall |=> !busy && done == cfg.steps)
    else $error("job ended with wrong pulse count");
  chk_phase_order: assert property (
    state == psg_pkg::ST_DECEL |=> state inside {psg_pkg::ST_DECEL, psg_pkg::ST_IDLE})
    else $error("deceleration left for a driving phase");
  chk_dir_held: assert property (
    busy && $past(busy) && !$past(en_fall) |-> $stable(dir_q))
    else $error("direction changed inside a train");
  chk_idle_disabled: assert property (
    !en_eff && state == psg_pkg::ST_IDLE |=> state == psg_pkg::ST_IDLE)
    else $error("job taken while disabled");
  chk_start_job: assert property (
    !busy && !cfg.ctrl[`PSG_C_ENREL] && start_rise && fs != '0 && cfg.steps != '0
    |=> state == psg_pkg::ST_ACCEL && cur == $past(fs))
    else $error("start edge did not begin job");
  chk_jog_hold: assert property (
    state == psg_pkg::ST_HOLD |-> cur == fs && !freq_jog)
    else $error("jog hold not at start frequency");
  chk_jog_switch: assert property (
    state == psg_pkg::ST_HOLD && cfg.ctrl[`PSG_C_JOG] && jog_tmr == TLAST && !last_step && !abort_rise
    && !en_fall
    |=> state == psg_pkg::ST_ACCEL && freq_jog)
    else $error("long jog did not switch to jog frequency");
  chk_jog_release: assert property (
    !en_fall && jog_let_go && state inside {psg_pkg::ST_ACCEL, psg_pkg::ST_RUN} |=> state == psg_pkg::ST_DECEL)
    else $error("jog release did not brake");
  chk_abort_brake: assert property (
    busy && abort_rise && state != psg_pkg::ST_DECEL && !last_step && !en_fall
    |=> state == psg_pkg::ST_DECEL ##0 stat.job_running)
    else $error("abort did not enter braking");
  chk_ramp_rate: assert property (
    state == psg_pkg::ST_ACCEL && step && !need_brake && !last_step && !abort_rise && !jog_let_go
    && !en_fall
    |=> cur - $past(cur) <= $past(cfg.ramp_up))
    else $error("acceleration exceeded ramp rate");

  cov_normal_done: cover property (state == psg_pkg::ST_RUN ##[1:1000] !busy);
  cov_freq_jog: cover property (freq_jog && state == psg_pkg::ST_RUN);
  cov_abort: cover property (busy && abort_rise);
  cov_short_jog: cover property (state == psg_pkg::ST_HOLD ##1 state == psg_pkg::ST_ACCEL && !freq_jog);
endmodule : psg_gen

module psg_top #(
  parameter int CLK_HZ = 50_000_000,
  parameter int JOG_HOLD_CYCLES = `PSG_JOG_HOLD_MS * (CLK_HZ / `PSG_MS_PER_S)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic pulse_pin_one,
  output logic pulse_pin_two,
  output logic direction_one,
  output logic direction_two,
  output logic [1:0] job_running
);
  if (CLK_HZ < `PSG_MS_PER_S || JOG_HOLD_CYCLES < 2) begin : g_bad
    $error("clock rate or jog hold count out of range");
  end

  psg_pkg::psg_cfg_s cfg [2];
  psg_pkg::psg_stat_s stat [2];
  logic [1:0] out_lvl, gen_pin, gen_dir, gen_act;
  logic aw_hold, w_hold;
  logic [7:0] waddr;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = a == `PSG_OUT_CTRL ||
                (!a[`PSG_GLB_BIT] && a[5:0] <= `PSG_CUR_MHZ && a[1:0] == 2'b00);
  endfunction : is_mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction : merge

  function automatic logic [31:0] rd_val(input logic [7:0] a);
    logic c;
    c = a[`PSG_CH_BIT];
    rd_val = '0;
    if (a == `PSG_OUT_CTRL) begin
      rd_val = 32'(out_lvl);
    end else if (!a[`PSG_GLB_BIT]) begin
      case (a[5:0])
        `PSG_CTRL: rd_val = 32'(cfg[c].ctrl);
        `PSG_STATUS: rd_val = 32'({stat[c].state, stat[c].freq_jog, stat[c].job_running});
        `PSG_STEPS: rd_val = cfg[c].steps;
        `PSG_START_HZ: rd_val = cfg[c].start_hz;
        `PSG_RUN_HZ: rd_val = cfg[c].run_hz;
        `PSG_JOG_HZ: rd_val = cfg[c].jog_hz;
        `PSG_RAMP_UP: rd_val = cfg[c].ramp_up;
        `PSG_RAMP_DOWN: rd_val = cfg[c].ramp_down;
        `PSG_DONE: rd_val = stat[c].steps_done;
        `PSG_CUR_MHZ: rd_val = stat[c].cur_mhz;
        default: rd_val = '0;
      endcase
    end
  endfunction : rd_val

  // -----------------------------------------------------------------
  // axi4-lite write and read channels
  // -----------------------------------------------------------------
  assign awready = !aw_hold && !bvalid;
  assign wready = !w_hold && !bvalid;
  assign arready = !rvalid;
  wire logic do_wr = aw_hold && w_hold && !bvalid;
  wire logic wr_ch = waddr[`PSG_CH_BIT];
  wire logic wr_cfg = do_wr && !waddr[`PSG_GLB_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `PSG_OKAY;
      waddr <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        waddr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= is_mapped(waddr) ? `PSG_OKAY : `PSG_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= '{default: '0};
      out_lvl <= '0;
    end else if (do_wr && waddr == `PSG_OUT_CTRL) begin
      out_lvl <= 2'(merge(32'(out_lvl), wdata_q, wstrb_q));
    end else if (wr_cfg) begin
      case (waddr[5:0])
        `PSG_CTRL: cfg[wr_ch].ctrl <= `PSG_CTRL_W'(merge(32'(cfg[wr_ch].ctrl), wdata_q, wstrb_q));
        `PSG_STEPS: cfg[wr_ch].steps <= merge(cfg[wr_ch].steps, wdata_q, wstrb_q);
        `PSG_START_HZ: cfg[wr_ch].start_hz <= merge(cfg[wr_ch].start_hz, wdata_q, wstrb_q);
        `PSG_RUN_HZ: cfg[wr_ch].run_hz <= merge(cfg[wr_ch].run_hz, wdata_q, wstrb_q);
        `PSG_JOG_HZ: cfg[wr_ch].jog_hz <= merge(cfg[wr_ch].jog_hz, wdata_q, wstrb_q);
        `PSG_RAMP_UP: cfg[wr_ch].ramp_up <= merge(cfg[wr_ch].ramp_up, wdata_q, wstrb_q);
        `PSG_RAMP_DOWN: cfg[wr_ch].ramp_down <= merge(cfg[wr_ch].ramp_down, wdata_q, wstrb_q);
        default: out_lvl <= out_lvl;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `PSG_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_val(araddr);
      rresp <= is_mapped(araddr) ? `PSG_OKAY : `PSG_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // generators and pin ownership
  // -----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_gen
    psg_gen #(.CLK_HZ(CLK_HZ), .JOG_HOLD_CYCLES(JOG_HOLD_CYCLES)) u_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg[g]),
      .stat(stat[g]),
      .step_pin(gen_pin[g]),
      .dir_pin(gen_dir[g]),
      .active(gen_act[g])
    );
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_pin_one <= 1'b0;
      pulse_pin_two <= 1'b0;
      direction_one <= 1'b0;
      direction_two <= 1'b0;
    end else begin
      pulse_pin_one <= gen_act[0] ? gen_pin[0] : out_lvl[0];
      pulse_pin_two <= gen_act[1] ? gen_pin[1] : out_lvl[1];
      direction_one <= gen_dir[0];
      direction_two <= gen_dir[1];
    end
  end

  assign job_running = {stat[1].job_running, stat[0].job_running};

  chk_pin_one_owner: assert property (@(posedge aclk) disable iff (!aresetn)
    gen_act[0] |=> pulse_pin_one == $past(gen_pin[0]))
    else $error("pin one not driven by its generator");
  chk_pin_two_owner: assert property (@(posedge aclk) disable iff (!aresetn)
    gen_act[1] |=> pulse_pin_two == $past(gen_pin[1]))
    else $error("pin two not driven by its generator");
endmodule : psg_top

//--- psg_map.svh
// register offsets, field positions and timing constants of the pulse generator
`ifndef PSG_MAP_SVH
`define PSG_MAP_SVH
// -----------------------------------------------------------------
// per-channel and global register offsets, channel window picked by address bit 6
// -----------------------------------------------------------------
`define PSG_CTRL 6'h00
`define PSG_STATUS 6'h04
`define PSG_STEPS 6'h08
`define PSG_START_HZ 6'h0C
`define PSG_RUN_HZ 6'h10
`define PSG_JOG_HZ 6'h14
`define PSG_RAMP_UP 6'h18
`define PSG_RAMP_DOWN 6'h1C
`define PSG_DONE 6'h20
`define PSG_CUR_MHZ 6'h24
`define PSG_OUT_CTRL 8'h80
`define PSG_CH_BIT 6
`define PSG_GLB_BIT 7
// -----------------------------------------------------------------
// control and status fields
// -----------------------------------------------------------------
`define PSG_C_ENREL 0
`define PSG_C_EN 1
`define PSG_C_START 2
`define PSG_C_JOG 3
`define PSG_C_ABORT 4
`define PSG_C_DIR 5
`define PSG_CTRL_W 6
`define PSG_STAT_W 5
// -----------------------------------------------------------------
// bus answers and timing
// -----------------------------------------------------------------
`define PSG_OKAY 2'b00
`define PSG_SLVERR 2'b10
`define PSG_JOG_HOLD_MS 500
`define PSG_MS_PER_S 1000
`define PSG_MHZ_PER_HZ 1000
`endif

//--- psg_pkg.sv
// types shared by the pulse generator files
package psg_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HOLD = 3'h1,
    ST_ACCEL = 3'h3,
    ST_RUN = 3'h2,
    ST_DECEL = 3'h6
  } psg_state_e;

  typedef struct packed {
    logic [5:0] ctrl;
    logic [31:0] steps;
    logic [31:0] start_hz;
    logic [31:0] run_hz;
    logic [31:0] jog_hz;
    logic [31:0] ramp_up;
    logic [31:0] ramp_down;
  } psg_cfg_s;

  typedef struct packed {
    logic job_running;
    logic freq_jog;
    psg_state_e state;
    logic [31:0] steps_done;
    logic [31:0] cur_mhz;
  } psg_stat_s;
endpackage : psg_pkg

//--- psg_drv_model.sv
// stepper driver input model: counts steps, times periods, watches direction
module psg_drv_model (
  input wire logic aclk,
  input wire logic clr,
  input wire logic step,
  input wire logic dir,
  output int cnt,
  output int first_per,
  output int min_per,
  output int last_per,
  output logic dir_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic step_q;
  logic dir_0;
  int gap;
  always @(posedge aclk) begin
    step_q <= step;
    gap <= gap + 1;
    if (clr) begin
      cnt <= 0;
      first_per <= 0;
      min_per <= 1_000_000;
      last_per <= 0;
      dir_bad <= 1'b0;
    end else if (step && !step_q) begin
      // optocoupler input takes one step per rising edge
      cnt <= cnt + 1;
      gap <= 1;
      if (cnt == 0) begin
        dir_0 <= dir;
      end else if (dir !== dir_0) begin
        dir_bad <= 1'b1;
      end
      if (cnt == 1) begin
        first_per <= gap;
      end
      if (cnt > 0 && gap < min_per) begin
        min_per <= gap;
      end
      if (cnt > 0) begin
        last_per <= gap;
      end
    end
  end
endmodule : psg_drv_model

//--- testbench.sv
// self-checking bench of the two channel pulse generator
`include "psg_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CLK = 100_000;
  localparam int HOLD = 200;
  localparam int FS = 5000;
  localparam int FJ = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, job_running;
  logic [31:0] rdata;
  logic pulse_pin_one, pulse_pin_two, direction_one, direction_two;
  logic clr = 1'b1;
  int cnt [2];
  int fp [2];
  int mp [2];
  int lp [2];
  logic db [2];
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int lo1, lo2, n;
  logic [31:0] seed;
  logic [31:0] dir;

  always #10 aclk = ~aclk;

  psg_top #(.CLK_HZ(CLK), .JOG_HOLD_CYCLES(HOLD)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pulse_pin_one(pulse_pin_one), .pulse_pin_two(pulse_pin_two),
    .direction_one(direction_one), .direction_two(direction_two), .job_running(job_running)
  );
  psg_drv_model drv0_u (.aclk(aclk), .clr(clr), .step(pulse_pin_one), .dir(direction_one),
    .cnt(cnt[0]), .first_per(fp[0]), .min_per(mp[0]), .last_per(lp[0]), .dir_bad(db[0]));
  psg_drv_model drv1_u (.aclk(aclk), .clr(clr), .step(pulse_pin_two), .dir(direction_two),
    .cnt(cnt[1]), .first_per(fp[1]), .min_per(mp[1]), .last_per(lp[1]), .dir_bad(db[1]));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int model(input bit rel, input bit en, input int steps);
    return (!rel || en) ? steps : 0;
  endfunction : model

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready && !aw) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    chk(bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk(rdata, e);
    chk(rresp, er);
  endtask : rd

  task automatic cfg(input int ch, input int steps, input int fr, input int rate);
    logic [7:0] b;
    b = 8'(ch * 64);
    wr(b + `PSG_STEPS, steps, `PSG_OKAY);
    wr(b + `PSG_START_HZ, FS, `PSG_OKAY);
    wr(b + `PSG_RUN_HZ, fr, `PSG_OKAY);
    wr(b + `PSG_JOG_HZ, FJ, `PSG_OKAY);
    wr(b + `PSG_RAMP_UP, rate, `PSG_OKAY);
    wr(b + `PSG_RAMP_DOWN, rate, `PSG_OKAY);
  endtask : cfg

  task automatic go(input int ch, input logic [31:0] c);
    wr(8'(ch * 64), c & 32'h0000_0023, `PSG_OKAY);
    wr(8'(ch * 64), c, `PSG_OKAY);
  endtask : go

  task automatic clear;
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    @(posedge aclk);
  endtask : clear

  task automatic run_wait(input int ch);
    lo1 = 0;
    lo2 = 0;
    repeat (4) @(posedge aclk);
    chk(job_running[ch], 1'b1);
    while (job_running[ch] === 1'b1) begin
      @(posedge aclk);
      lo1 += int'(pulse_pin_one === 1'b0);
      lo2 += int'(pulse_pin_two === 1'b0);
    end
    repeat (4) @(posedge aclk);
  endtask : run_wait

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    seed = 32'h0001_6605;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    rd(`PSG_CTRL, 0, `PSG_OKAY);
    rd(`PSG_STATUS, 0, `PSG_OKAY);
    rd(`PSG_OUT_CTRL, 0, `PSG_OKAY);
    rd(8'hFC, 0, `PSG_SLVERR);
    wr(8'hFC, 1, `PSG_SLVERR);
    // normal job with a repeated start while busy
    seed = lfsr(seed);
    // at least 12 steps: braking shows in the last period, jog hold cannot use up the count
    n = 12 + int'(seed[2:0]);
    dir = {31'h0, seed[3]};
    cfg(0, n, 10000, 1_000_000);
    go(0, 7 | dir << 5);
    go(0, 7 | dir << 5);
    run_wait(0);
    chk(cnt[0], model(1, 1, n));
    chk(fp[0], CLK / FS);
    chk(mp[0] < CLK / FS, 1);
    chk(lp[0] > mp[0], 1);
    chk(db[0], 1'b0);
    chk(direction_one, dir[0]);
    chk(cnt[1], 0);
    rd(`PSG_DONE, n, `PSG_OKAY);
    // enable gating
    clear();
    go(0, 5);
    repeat (10) @(posedge aclk);
    chk(job_running[0], 1'b0);
    chk(cnt[0], model(1, 0, n));
    go(0, 4);
    run_wait(0);
    chk(cnt[0], model(0, 0, n));
    // short jog on channel two
    clear();
    cfg(1, n, 10000, 1_000_000);
    go(1, 3 | 8);
    repeat (50) @(posedge aclk);
    wr(8'h40, 3, `PSG_OKAY);
    run_wait(1);
    chk(cnt[1], n);
    chk(fp[1], CLK / FS);
    chk(cnt[0], 0);
    // long jog on channel two
    clear();
    go(1, 3 | 8 | 32);
    rd(8'h44, 5, `PSG_OKAY);
    repeat (600) @(posedge aclk);
    chk(fp[1], CLK / FS);
    chk(mp[1], CLK / FJ);
    rd(8'h44, 11, `PSG_OKAY);
    wr(8'h40, 3, `PSG_OKAY);
    run_wait(1);
    chk(lp[1] > mp[1], 1);
    chk(direction_two, 1'b1);
    chk(db[1], 1'b0);
    // abort with program levels on both pins
    cfg(0, 1000, 10000, 1_000_000);
    wr(`PSG_OUT_CTRL, 3, `PSG_OKAY);
    clear();
    go(0, 7);
    repeat (300) @(posedge aclk);
    wr(`PSG_CTRL, 7 | 16, `PSG_OKAY);
    repeat (2) @(posedge aclk);
    chk(job_running[0], 1'b1);
    run_wait(0);
    chk(cnt[0] < 1000, 1);
    chk(lp[0] > mp[0], 1);
    chk(lo1 > 0, 1);
    chk(lo2, 0);
    chk(pulse_pin_one, 1'b1);
    finish_test();
  end
endmodule : testbench
